// ==== verification/pmpd_far_model.sv ====
`default_nettype none
module pmpd_far_model (
  input  wire logic       irq_any_req_i,
  input  wire logic       irq_en_req_i,
  input  wire logic       strap_drive_i,
  input  wire logic [1:0] strap_val_i,
  output logic            ratio_hi_o,
  output logic            ratio_lo_o,
  output logic            irq_any_o,
  output logic            irq_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Straps: undriven pins fall to the pulldown level
  // ----------------------------------------------------------------
  assign ratio_hi_o = strap_drive_i ? strap_val_i[1] : 1'b0;
  assign ratio_lo_o = strap_drive_i ? strap_val_i[0] : 1'b0;
  // ----------------------------------------------------------------
  // Core interrupt lines
  // ----------------------------------------------------------------
  // An enabled interrupt is also an interrupt, so it shows on both lines
  assign irq_any_o = irq_any_req_i | irq_en_req_i;
  assign irq_en_o  = irq_en_req_i;
endmodule : pmpd_far_model
`default_nettype wire

// ==== verification/pmpd_power_ctrl_tb.sv ====
`default_nettype none
`define CHK(A, E, M) begin cmp_count++; if ((A) !== (E)) begin n_fail++; $display("mismatch at %0t: %s", $time, M); end end
module pmpd_power_ctrl_tb;
  import pmpd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned LW = 20;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic irq_any_req = 1'b0, irq_en_req = 1'b0, strap_drive = 1'b0;
  logic [1:0]  strap_val = 2'h0;
  logic ratio_hi, ratio_lo, irq_any, irq_en, pready, pslverr, cpu_en, pll_out_en, pll_in_en;
  logic locked, dma_en, freeze, resume, take_isr, aux4, aux6;
  logic [31:0] prdata, rd;
  logic [4:0]  mult;
  logic        err;
  logic        a4p, a6p;
  int n_fail = 0, cmp_count = 0, n_resume = 0, n;
  logic [4:0] exp_mult [4] = '{MULT_X1, MULT_X6, MULT_X12, MULT_X20};
  logic [5:0] deep_mode [2] = '{SLEEP_PLL_OUT, SLEEP_PLL_IN};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (resume === 1'b1) n_resume++;
  pmpd_far_model pmpd_far_model_inst (.irq_any_req_i(irq_any_req), .irq_en_req_i(irq_en_req),
    .strap_drive_i(strap_drive), .strap_val_i(strap_val), .ratio_hi_o(ratio_hi),
    .ratio_lo_o(ratio_lo), .irq_any_o(irq_any), .irq_en_o(irq_en));
  pmpd_power_ctrl #(.LOCK_WAIT_CYC(LW)) pmpd_power_ctrl_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n),
    .RATIO_SELECT_HI_I(ratio_hi), .RATIO_SELECT_LO_I(ratio_lo), .IRQ_ANY_I(irq_any),
    .IRQ_ENABLED_I(irq_en), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready), .PRDATA_O(prdata),
    .PSLVERR_O(pslverr), .CPU_CLK_EN_O(cpu_en), .PLL_OUT_EN_O(pll_out_en),
    .PLL_IN_EN_O(pll_in_en), .PLL_LOCKED_O(locked), .CLK_MULT_O(mult), .DMA_EN_O(dma_en),
    .IO_FREEZE_O(freeze), .RESUME_O(resume), .TAKE_ISR_O(take_isr),
    .AUX_CLOCK_DIV_FOUR_O(aux4), .AUX_CLOCK_DIV_SIX_O(aux6));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; pstrb <= 4'hf; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin n_fail++; $display("mismatch at %0t: no bus answer", $time); give_verdict(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Ratio pins are driven to the inverted value two cycles after reset, so a held multiplier proves the capture
  task automatic do_reset(input logic drv, input logic [1:0] val);
    rst_n <= 1'b0; strap_drive <= drv; strap_val <= val;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    strap_drive <= 1'b1; strap_val <= ~val;
    n = 0;
    while (locked !== 1'b1 && n < LW + 20) begin @(posedge clk); n++; end
    if (locked !== 1'b1) begin n_fail++; $display("mismatch at %0t: no lock", $time); give_verdict(); end
  endtask : do_reset
  task automatic wait_fall();
    n = 0;
    do begin @(posedge clk); n++; end while (cpu_en !== 1'b0 && n < 20);
    if (cpu_en !== 1'b0) begin n_fail++; $display("mismatch at %0t: no halt", $time); give_verdict(); end
  endtask : wait_fall
  task automatic wait_resume();
    n = 0;
    do begin @(posedge clk); n++; end while (resume !== 1'b1 && n < 12);
    if (n >= 12) begin n_fail++; $display("mismatch at %0t: no wake", $time); give_verdict(); end
  endtask : wait_resume
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    for (int r = 0; r < 4; r++) begin
      do_reset(r != 0, 2'(r));
      `CHK(mult, exp_mult[r], "multiplier")
      `CHK(n >= ((r == 0) ? 0 : LW) && n <= ((r == 0) ? 3 : LW + 5), 1'b1, "lock wait")
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK(rd[8:4], exp_mult[r], "status multiplier")
      `CHK(rd[1:0], 2'h3, "status locked and running")
    end
    do_reset(1'b0, 2'h0);
    `CHK(mult, MULT_X1, "pulldown bypass")
    apb(1'b0, CSR_OFFSET, 32'h0);
    `CHK(rd, 32'h0, "sleep field reset")
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK(err, 1'b1, "unmapped slave error")
    n = 0;
    a4p = aux4;
    a6p = aux6;
    for (int c = 0; c < 24; c++) begin
      @(posedge clk);
      n += (aux4 !== a4p) + (aux6 !== a6p) * 16;
      a4p = aux4;
      a6p = aux6;
    end
    `CHK(n, 12 + 8 * 16, "aux toggle counts")
    apb(1'b1, CSR_OFFSET, 32'hffff_0fff);
    apb(1'b0, CSR_OFFSET, 32'h0);
    `CHK(rd, 32'h0000_0c00, "reserved code stored, other bits zero")
    repeat (12) @(posedge clk);
    `CHK(cpu_en, 1'b1, "reserved code does not sleep")
    // Shallow halt woken by enabled interrupt; a plain interrupt must not wake it
    apb(1'b1, CSR_OFFSET, {16'h0, SLEEP_HALT_EN, 10'h0});
    wait_fall();
    `CHK(n, 9, "halt delay")
    `CHK({dma_en, pll_out_en, pll_in_en, freeze}, 4'he, "halt keeps dma and pll")
    n = 0;
    a4p = aux4;
    for (int c = 0; c < 12; c++) begin
      @(posedge clk);
      n += (aux4 !== a4p);
      a4p = aux4;
    end
    `CHK(n, 0, "aux gated in halt")
    irq_any_req <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK({cpu_en, n_resume}, {1'b0, 32'd0}, "plain interrupt ignored")
    irq_en_req <= 1'b1;
    wait_resume();
    `CHK({take_isr, cpu_en}, 2'h3, "enabled wake services interrupt")
    irq_en_req <= 1'b0; irq_any_req <= 1'b0;
    apb(1'b0, CSR_OFFSET, 32'h0);
    `CHK(rd, 32'h0, "field cleared on wake")
    // Shallow halt woken by any interrupt
    apb(1'b1, CSR_OFFSET, {16'h0, SLEEP_HALT_ANY, 10'h0});
    wait_fall();
    `CHK(n, 9, "halt delay any")
    irq_any_req <= 1'b1;
    wait_resume();
    `CHK({take_isr, cpu_en}, 2'h1, "plain wake resumes without service")
    irq_any_req <= 1'b0;
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, CSR_OFFSET, {16'h0, deep_mode[d], 10'h0});
      wait_fall();
      `CHK(n, 9, "deep delay")
      `CHK({pll_out_en, pll_in_en}, {1'b0, d == 0}, "pll stop")
      `CHK({dma_en, freeze}, 2'h1, "deep freeze")
      n = n_resume;
      irq_en_req <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK({cpu_en, n_resume}, {1'b0, n}, "deep ignores interrupts")
      irq_en_req <= 1'b0;
      do_reset(1'b1, 2'h1);
      `CHK({pll_in_en, freeze, locked}, 3'h5, "reset leaves deep sleep")
      `CHK(n >= LW, 1'b1, "relock after reset")
    end
    give_verdict();
  end
endmodule : pmpd_power_ctrl_tb
`default_nettype wire

// ==== verilog/pmpd_clk_div.sv ====
`default_nettype none
module pmpd_clk_div #(
  parameter int unsigned DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  pmpd_div_if.div   port_if
);
  localparam int unsigned HALF = DIV / 2;
  localparam int unsigned CW   = (HALF > 1) ? $clog2(HALF) : 1;

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          out_reg;
  logic          out_next;

  // Counts CPU clock ticks only, so it stops whenever the CPU clock is gated
  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (port_if.tick) begin
      if (cnt_reg == CW'(HALF - 1)) begin
        cnt_next = '0;
        out_next = ~out_reg;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign port_if.clk_out = out_reg;
endmodule : pmpd_clk_div
`default_nettype wire

// ==== verilog/pmpd_div_if.sv ====
`default_nettype none
interface pmpd_div_if;
  logic tick;
  logic clk_out;
  modport div  (input tick, output clk_out);
  modport ctrl (output tick, input clk_out);
endinterface : pmpd_div_if
`default_nettype wire

// ==== verilog/pmpd_pkg.sv ====
`default_nettype none
package pmpd_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned LOCK_TYP_US     = 75;
  localparam int unsigned LOCK_MARGIN_PCT = 150;
  localparam int unsigned LOCK_MAX_NS     = LOCK_TYP_US * 1000 * (100 + LOCK_MARGIN_PCT) / 100;
  localparam int unsigned LOCK_CYCLES     = (LOCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_DELAY_CYC = 8;
  localparam int unsigned AUX_DIV_FOUR    = 4;
  localparam int unsigned AUX_DIV_SIX     = 6;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] CSR_OFFSET     = 12'h000;
  localparam logic [11:0] STATUS_OFFSET  = 12'h004;
  localparam int unsigned SLEEP_LSB      = 10;
  localparam int unsigned SLEEP_W        = 6;
  localparam int unsigned STAT_LOCK_BIT  = 0;
  localparam int unsigned STAT_CLKEN_BIT = 1;
  localparam int unsigned STAT_HALT_BIT  = 2;
  localparam int unsigned STAT_DEEP_BIT  = 3;
  localparam int unsigned STAT_MULT_LSB  = 4;
  localparam int unsigned MULT_W         = 5;

  localparam logic [5:0] SLEEP_RESET    = 6'h00;
  localparam logic [5:0] SLEEP_NONE     = 6'h00;
  localparam logic [5:0] SLEEP_HALT_EN  = 6'h09;
  localparam logic [5:0] SLEEP_HALT_ANY = 6'h11;
  localparam logic [5:0] SLEEP_PLL_OUT  = 6'h1a;
  localparam logic [5:0] SLEEP_PLL_IN   = 6'h1c;

  localparam logic [1:0] RATIO_BYPASS = 2'h0;
  localparam logic [1:0] RATIO_X6     = 2'h1;
  localparam logic [1:0] RATIO_X12    = 2'h2;
  localparam logic [4:0] MULT_X1      = 5'h01;
  localparam logic [4:0] MULT_X6      = 5'h06;
  localparam logic [4:0] MULT_X12     = 5'h0c;
  localparam logic [4:0] MULT_X20     = 5'h14;

  typedef enum logic [2:0] {ST_RUN, ST_ARM, ST_HALT, ST_PLL_OUT, ST_PLL_IN} pmpd_state_t;

  function automatic logic [4:0] pmpd_mult_of(input logic [1:0] ratio);
    case (ratio)
      RATIO_BYPASS: pmpd_mult_of = MULT_X1;
      RATIO_X6:     pmpd_mult_of = MULT_X6;
      RATIO_X12:    pmpd_mult_of = MULT_X12;
      default:      pmpd_mult_of = MULT_X20;
    endcase
  endfunction : pmpd_mult_of

  function automatic logic pmpd_is_sleep(input logic [5:0] field);
    pmpd_is_sleep = (field == SLEEP_HALT_EN) || (field == SLEEP_HALT_ANY) ||
                    (field == SLEEP_PLL_OUT) || (field == SLEEP_PLL_IN);
  endfunction : pmpd_is_sleep
endpackage : pmpd_pkg
`default_nettype wire

// ==== verilog/pmpd_power_ctrl.sv ====
// How it works
// (RULE1) CPU clock comes from the reference input, bypassed or PLL multiplied.
// (RULE2) Ratio pins 00 bypass, 01 x6, 10 x12, 11 x20.
// (RULE3) Undriven ratio pins read zero through pulldowns, giving bypass.
// (RULE4) Lock wait in multiply modes allows typical time plus 150 percent.
// (RULE5) Sleep gates only the main reference path; other input clocks run on.
// (RULE6) Sleep field sits in control bits 15..10, all resetting to zero.
// (RULE7) Software writes the whole six-bit sleep field at once.
// (RULE8) Software writes zero to reserved bit 15.
// (RULE9) Shallow halt takes effect eight cycles after the field write.
// (RULE10) Non-enabled interrupt wake resumes without servicing the interrupt.
// (RULE11) Enabled interrupt wake services the interrupt first, then resumes.
// (RULE12) Deeper sleeps ignore interrupts; only reset leaves them.
// (RULE13) Encodings 000000, 001001, 010001, 011010, 011100; others reserved.
// (RULE14) Shallow halt gates the CPU clock, interrupt logic and DMA keep running.
// (RULE15) Middle stops PLL output, deepest stops PLL input; state kept, pins frozen.
// (RULE16) Aux clocks are the CPU clock divided by four and by six.
// (RULE17) Ratio pins are sampled during reset and held until next reset.
//
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
module pmpd_power_ctrl
  import pmpd_pkg::*;
#(
  parameter int unsigned LOCK_WAIT_CYC = LOCK_CYCLES
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  input  wire logic        RATIO_SELECT_HI_I,
  input  wire logic        RATIO_SELECT_LO_I,
  input  wire logic        IRQ_ANY_I,
  input  wire logic        IRQ_ENABLED_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic             PREADY_O,
  output logic [31:0]      PRDATA_O,
  output logic             PSLVERR_O,
  output logic             CPU_CLK_EN_O,
  output logic             PLL_OUT_EN_O,
  output logic             PLL_IN_EN_O,
  output logic             PLL_LOCKED_O,
  output logic [4:0]       CLK_MULT_O,
  output logic             DMA_EN_O,
  output logic             IO_FREEZE_O,
  output logic             RESUME_O,
  output logic             TAKE_ISR_O,
  output logic             AUX_CLOCK_DIV_FOUR_O,
  output logic             AUX_CLOCK_DIV_SIX_O
);
  localparam int unsigned LW = $clog2(LOCK_WAIT_CYC + 1);
  localparam int unsigned DW = $clog2(SLEEP_DELAY_CYC);

  // ----------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ----------------------------------------------------------------
  logic [1:0] ratio_meta_reg;
  logic [1:0] ratio_sync_reg;
  logic       strap_done_reg;
  logic       strap_done_next;
  logic [1:0] ratio_reg;
  logic [1:0] ratio_next;

  // No reset here so the pins are already sampled while reset is held
  always_ff @(posedge CLK_SYS_I) begin
    ratio_meta_reg <= {RATIO_SELECT_HI_I, RATIO_SELECT_LO_I};
    ratio_sync_reg <= ratio_meta_reg;
  end

  always_comb begin
    strap_done_next = 1'b1;
    ratio_next      = ratio_reg;
    if (!strap_done_reg) begin
      ratio_next = ratio_sync_reg; // RULE17 RULE3
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      strap_done_reg <= 1'b0;
      ratio_reg      <= RATIO_BYPASS;
    end else begin
      strap_done_reg <= strap_done_next;
      ratio_reg      <= ratio_next;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic        pready_reg;
  logic        pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        acc_first;
  logic        acc_done;
  logic        hit_csr;
  logic        hit_stat;
  logic        wr_csr;
  logic [5:0]  sleep_reg;
  logic [5:0]  sleep_next;
  logic [31:0] csr_word;
  logic [31:0] stat_word;

  pmpd_state_t state_reg;
  pmpd_state_t state_next;
  logic        locked_reg;

  assign hit_csr   = (PADDR_I[11:2] == CSR_OFFSET[11:2]);
  assign hit_stat  = (PADDR_I[11:2] == STATUS_OFFSET[11:2]);
  assign acc_first = PSEL_I & PENABLE_I & ~pready_reg;
  assign acc_done  = PSEL_I & PENABLE_I & pready_reg;
  assign wr_csr    = acc_done & PWRITE_I & hit_csr & PSTRB_I[1];

  always_comb begin
    csr_word                               = '0;
    csr_word[SLEEP_LSB +: SLEEP_W]         = sleep_reg; // RULE6
    stat_word                              = '0;
    stat_word[STAT_LOCK_BIT]               = locked_reg;
    stat_word[STAT_CLKEN_BIT]              = CPU_CLK_EN_O;
    stat_word[STAT_HALT_BIT]               = (state_reg == ST_HALT);
    stat_word[STAT_DEEP_BIT]               = (state_reg == ST_PLL_OUT) || (state_reg == ST_PLL_IN);
    stat_word[STAT_MULT_LSB +: MULT_W]     = CLK_MULT_O;
    pready_next  = acc_first;
    pslverr_next = acc_first & ~(hit_csr | hit_stat);
    prdata_next  = prdata_reg;
    if (acc_first && !PWRITE_I) begin
      prdata_next = hit_csr ? csr_word : (hit_stat ? stat_word : '0);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // PLL lock tracking
  // ----------------------------------------------------------------
  logic [LW-1:0] lock_cnt_reg;
  logic [LW-1:0] lock_cnt_next;
  logic          locked_next;

  always_comb begin
    lock_cnt_next = lock_cnt_reg;
    locked_next   = locked_reg;
    // Lock drops at the edge the PLL input stops, so status never shows a stale lock
    if (!strap_done_reg || state_next == ST_PLL_IN) begin
      lock_cnt_next = '0; // RULE15
      locked_next   = 1'b0;
    end else if (ratio_reg == RATIO_BYPASS) begin
      locked_next = 1'b1; // RULE1 RULE4
    end else if (lock_cnt_reg == LW'(LOCK_WAIT_CYC)) begin
      locked_next = 1'b1; // RULE4
    end else begin
      lock_cnt_next = lock_cnt_reg + LW'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      lock_cnt_reg <= '0;
      locked_reg   <= 1'b0;
    end else begin
      lock_cnt_reg <= lock_cnt_next;
      locked_reg   <= locked_next;
    end
  end

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  logic [DW-1:0] dly_reg;
  logic [DW-1:0] dly_next;
  logic          resume_next;
  logic          isr_next;
  logic          wake;

  assign wake = IRQ_ENABLED_I | ((sleep_reg == SLEEP_HALT_ANY) & IRQ_ANY_I);

  always_comb begin
    state_next  = state_reg;
    sleep_next  = sleep_reg;
    dly_next    = dly_reg;
    resume_next = 1'b0;
    isr_next    = 1'b0;
    case (state_reg)
      ST_RUN: begin
        // The field is only accepted whole; a halted core cannot issue writes
        if (wr_csr) begin
          sleep_next = PWDATA_I[SLEEP_LSB +: SLEEP_W]; // RULE6 RULE7
          dly_next   = '0;
          if (pmpd_is_sleep(PWDATA_I[SLEEP_LSB +: SLEEP_W])) begin
            state_next = ST_ARM; // RULE13
          end
        end
      end
      ST_ARM: begin
        dly_next = dly_reg + DW'(1);
        if (dly_reg == DW'(SLEEP_DELAY_CYC - 1)) begin
          case (sleep_reg) // RULE9 RULE13
            SLEEP_PLL_OUT: state_next = ST_PLL_OUT;
            SLEEP_PLL_IN:  state_next = ST_PLL_IN;
            default:       state_next = ST_HALT;
          endcase
        end
      end
      ST_HALT: begin
        if (wake) begin
          state_next  = ST_RUN;
          sleep_next  = SLEEP_NONE;
          resume_next = 1'b1; // RULE10
          isr_next    = IRQ_ENABLED_I; // RULE11
        end
      end
      ST_PLL_OUT,
      ST_PLL_IN: begin
        state_next = state_reg; // RULE12
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic cpu_en_next;
  logic pll_out_next;
  logic pll_in_next;
  logic dma_next;
  logic freeze_next;
  logic deep_next;

  // Only the reference path is gated; no other input clock passes here
  always_comb begin
    deep_next    = (state_next == ST_PLL_OUT) || (state_next == ST_PLL_IN);
    cpu_en_next  = locked_next & ((state_next == ST_RUN) || (state_next == ST_ARM)); // RULE5 RULE14
    pll_out_next = ~deep_next; // RULE15
    pll_in_next  = (state_next != ST_PLL_IN); // RULE15
    dma_next     = ~deep_next; // RULE14
    freeze_next  = deep_next; // RULE15
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg    <= ST_RUN;
      sleep_reg    <= SLEEP_RESET;
      dly_reg      <= '0;
      RESUME_O     <= 1'b0;
      TAKE_ISR_O   <= 1'b0;
      CPU_CLK_EN_O <= 1'b0;
      PLL_OUT_EN_O <= 1'b1;
      PLL_IN_EN_O  <= 1'b1;
      DMA_EN_O     <= 1'b1;
      IO_FREEZE_O  <= 1'b0;
      CLK_MULT_O   <= MULT_X1;
    end else begin
      state_reg    <= state_next;
      sleep_reg    <= sleep_next;
      dly_reg      <= dly_next;
      RESUME_O     <= resume_next;
      TAKE_ISR_O   <= isr_next;
      CPU_CLK_EN_O <= cpu_en_next;
      PLL_OUT_EN_O <= pll_out_next;
      PLL_IN_EN_O  <= pll_in_next;
      DMA_EN_O     <= dma_next;
      IO_FREEZE_O  <= freeze_next;
      CLK_MULT_O   <= pmpd_mult_of(ratio_reg); // RULE2
    end
  end

  assign PREADY_O     = pready_reg;
  assign PRDATA_O     = prdata_reg;
  assign PSLVERR_O    = pslverr_reg;
  assign PLL_LOCKED_O = locked_reg;

  // ----------------------------------------------------------------
  // Auxiliary clocks
  // ----------------------------------------------------------------
  localparam int unsigned AUX_DIVS [2] = '{AUX_DIV_FOUR, AUX_DIV_SIX};
  logic [1:0] aux_q;

  for (genvar g = 0; g < 2; g++) begin : g_aux
    pmpd_div_if div_if ();
    assign div_if.tick = CPU_CLK_EN_O; // RULE16
    assign aux_q[g]    = div_if.clk_out;
    pmpd_clk_div #(.DIV(AUX_DIVS[g])) u_div (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RESETN_I),
      .port_if (div_if.div)
    );
  end

  assign AUX_CLOCK_DIV_FOUR_O = aux_q[0];
  assign AUX_CLOCK_DIV_SIX_O  = aux_q[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  a_halt_delay: assert property ((state_reg == ST_RUN) && wr_csr && locked_reg && // RULE9
    ((PWDATA_I[SLEEP_LSB +: SLEEP_W] == SLEEP_HALT_EN) || (PWDATA_I[SLEEP_LSB +: SLEEP_W] == SLEEP_HALT_ANY))
    |=> CPU_CLK_EN_O [*8] ##1 !CPU_CLK_EN_O)
    else $error("halt did not take effect after eight cycles");
  a_deep_stays: assert property ((state_reg == ST_PLL_OUT) || (state_reg == ST_PLL_IN) |=> // RULE12
    $stable(state_reg) && !RESUME_O)
    else $error("deep sleep left without reset");
  a_deep_effects: assert property ((state_reg == ST_PLL_IN) |-> // RULE15
    !PLL_IN_EN_O && !PLL_OUT_EN_O && !CPU_CLK_EN_O && IO_FREEZE_O && !PLL_LOCKED_O)
    else $error("deepest sleep effects wrong");
  a_halt_dma: assert property ((state_reg == ST_HALT) |-> DMA_EN_O && !CPU_CLK_EN_O && PLL_OUT_EN_O) // RULE14
    else $error("shallow halt gating wrong");
  a_wake_isr: assert property ((state_reg == ST_HALT) && IRQ_ENABLED_I |=> // RULE11
    RESUME_O && TAKE_ISR_O && (state_reg == ST_RUN) && (sleep_reg == SLEEP_NONE))
    else $error("enabled interrupt wake wrong");
  a_wake_any: assert property ((state_reg == ST_HALT) && (sleep_reg == SLEEP_HALT_ANY) && IRQ_ANY_I && // RULE10
    !IRQ_ENABLED_I |=> RESUME_O && !TAKE_ISR_O)
    else $error("non-enabled interrupt wake wrong");
  a_halt_hold: assert property ((state_reg == ST_HALT) && (sleep_reg == SLEEP_HALT_EN) && !IRQ_ENABLED_I // RULE13
    |=> (state_reg == ST_HALT))
    else $error("halt left without enabled interrupt");
  a_bypass_lock: assert property (strap_done_reg && (ratio_reg == RATIO_BYPASS) |=> PLL_LOCKED_O == PLL_IN_EN_O) // RULE3
    else $error("bypass not locked at once");
  a_mult_map: assert property (strap_done_reg |=> CLK_MULT_O == pmpd_mult_of(ratio_reg)) // RULE2
    else $error("multiplier does not follow strap");
  a_strap_hold: assert property (strap_done_reg |=> $stable(ratio_reg)) // RULE17
    else $error("strap changed after reset");
  a_lock_wait: assert property ($rose(PLL_LOCKED_O) && (ratio_reg != RATIO_BYPASS) |-> // RULE4
    $past(lock_cnt_reg) == LW'(LOCK_WAIT_CYC))
    else $error("lock declared early");

  c_halt:  cover property ((state_reg == ST_ARM) ##8 (state_reg == ST_HALT));
  c_isr:   cover property (RESUME_O && TAKE_ISR_O);
  c_deep:  cover property (state_reg == ST_PLL_OUT);
  c_lock:  cover property ($rose(PLL_LOCKED_O) && (ratio_reg != RATIO_BYPASS));
endmodule : pmpd_power_ctrl
`default_nettype wire
